//--- hdl/codec_pkg.sv
// constants and types shared by the manchester codec files
// assumes a 50 mhz core clock feeding every module of the codec
package codec_pkg;
  // times in nanoseconds, as figures
  localparam int CLK_NS     = 20;
  localparam int BIT_NS     = 100;
  localparam int MII_CLK_NS = 400;
  localparam int SER_CLK_NS = 100;
  // derived cycle counts
  localparam int BIT_CYC  = BIT_NS / CLK_NS;
  localparam int NIB_DIV  = MII_CLK_NS / CLK_NS;
  localparam int SER_DIV  = SER_CLK_NS / CLK_NS;
  localparam int HALF_CYC = (BIT_CYC + 1) / 2;
  // divider constants at divider width
  localparam logic [4:0] NIB_LAST = 5'(NIB_DIV - 1);
  localparam logic [4:0] SER_LAST = 5'(SER_DIV - 1);
  localparam logic [4:0] NIB_HALF = 5'(NIB_DIV / 2);
  localparam logic [4:0] SER_HALF = 5'(SER_DIV / 2);
  localparam logic [4:0] BIT_LEN  = 5'(BIT_CYC);
  localparam logic [4:0] HALF_LEN = 5'(HALF_CYC);
  // receive edge timing, in core cycles since the last mid-bit edge
  localparam logic [3:0] GAP_MAX      = 4'hf;
  localparam logic [3:0] MID_MIN      = 4'h3;
  localparam logic [3:0] CARRIER_LOSS = 4'h8;
  // preamble bit alternations needed before a start delimiter counts
  localparam logic [3:0] PRE_MIN = 4'h6;
  // receive buffer shape
  localparam int FIFO_W = 4;
  localparam int FIFO_D = 16;
  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_PRE  = 2'b01,
    RX_DATA = 2'b11
  } rx_state_t;
endpackage

//--- hdl/elastic_fifo.sv
// small fifo with registered read data and honest full/empty
// assumes synchronous active-high reset on the shared clock
`timescale 1ns/10ps
module elastic_fifo #(
  parameter int W = 4,
  parameter int D = 16
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  stream_if.store   s
);
  localparam int AW = $clog2(D);
  localparam logic [AW:0] CNT_FULL = (AW + 1)'(D);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wp;
    logic [AW-1:0]       rp;
    logic [AW:0]         cnt;
    logic                ov;
    logic [W-1:0]        od;
  } fifo_st_t;

  fifo_st_t r;
  fifo_st_t n;
  logic     push;
  logic     pop;

  // ready and output stage straight from flops
  assign s.wr_ready = (r.cnt != CNT_FULL);
  assign s.rd_valid = r.ov;
  assign s.rd_data  = r.od;

  // write, refill output register, keep count
  always_comb begin
    n    = r;
    push = s.wr_valid && (r.cnt != CNT_FULL);
    pop  = (r.cnt != '0) && (!r.ov || s.rd_ready);
    if (push) begin
      n.mem[r.wp] = s.wr_data;
      n.wp        = r.wp + 1'b1;
    end
    if (s.rd_ready && r.ov) begin
      n.ov = 1'b0;
    end
    if (pop) begin
      n.od = r.mem[r.rp];
      n.rp = r.rp + 1'b1;
      n.ov = 1'b1;
    end
    n.cnt = r.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end
endmodule

//--- hdl/stream_if.sv
// valid/ready stream carrier between the codec and its receive buffer
// assumes both ends run on the same clock
`timescale 1ns/10ps
interface stream_if #(parameter int W = 4);
  logic         wr_valid;
  logic         wr_ready;
  logic [W-1:0] wr_data;
  logic         rd_valid;
  logic         rd_ready;
  logic [W-1:0] rd_data;
  modport store  (input wr_valid, wr_data, rd_ready, output wr_ready, rd_valid, rd_data);
  modport client (output wr_valid, wr_data, rd_ready, input wr_ready, rd_valid, rd_data);
endinterface

//--- hdl/tenbase_manchester_codec.sv
// ten-megabit manchester line codec with mac-side clock synthesis
// assumes a 50 mhz clk_i; line receive pins are asynchronous to it
`timescale 1ns/10ps
module tenbase_manchester_codec (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       serial_mode_i,
  input  wire logic       speed_100_i,
  input  wire logic       autoneg_i,
  input  wire logic       tx_en_i,
  input  wire logic [3:0] tx_data_i,
  input  wire logic       mlt3_pos_i,
  input  wire logic       mlt3_neg_i,
  input  wire logic       line_rx_pos_i,
  input  wire logic       line_rx_neg_i,
  output logic            mac_clk_o,
  output logic            rx_dv_o,
  output logic [3:0]      rx_data_o,
  output logic            rx_overrun_o,
  output logic            polarity_reversed_o,
  output logic            line_tx_pos_o,
  output logic            line_tx_neg_o
);
  typedef struct packed {
    logic [4:0]           div;
    logic                 mclk;
    logic [3:0]           tsh;
    logic                 tact;
    logic                 ltp;
    logic                 ltn;
    logic                 rp1;
    logic                 rp2;
    logic                 rn1;
    logic                 rn2;
    logic                 rlv;
    logic [3:0]           gc;
    codec_pkg::rx_state_t rst;
    logic [3:0]           ac;
    logic                 lb;
    logic                 pol;
    logic [3:0]           rsh;
    logic [1:0]           nc;
    logic                 wv;
    logic [3:0]           wd;
    logic                 ovr;
    logic                 rdv;
    logic [3:0]           rdat;
  } codec_st_t;

  codec_st_t  r;
  codec_st_t  n;
  logic [4:0] last;
  logic [4:0] half;
  logic       tick;
  logic       fall;
  logic [1:0] bidx;
  logic [4:0] bc;
  logic       bitv;
  logic       first;
  logic       act;
  logic       raw;
  logic       edge_seen;
  logic       mid;
  logic       rbit;
  logic       pol_en;

  stream_if #(.W(codec_pkg::FIFO_W)) q ();

  elastic_fifo #(.W(codec_pkg::FIFO_W), .D(codec_pkg::FIFO_D)) u_rx_fifo (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .s     (q.store)
  );

  // buffer hookup; reads happen on the falling mac clock edge
  assign q.wr_valid = r.wv;
  assign q.wr_data  = r.wd;
  assign q.rd_ready = fall;

  // outputs straight from state
  assign mac_clk_o           = r.mclk;
  assign rx_dv_o             = r.rdv;
  assign rx_data_o           = r.rdat;
  assign rx_overrun_o        = r.ovr;
  assign polarity_reversed_o = r.pol;
  assign line_tx_pos_o       = r.ltp;
  assign line_tx_neg_o       = r.ltn;

  always_comb begin
    n         = r;
    // mac clock divider, period chosen by interface mode
    last      = serial_mode_i ? codec_pkg::SER_LAST : codec_pkg::NIB_LAST;
    half      = serial_mode_i ? codec_pkg::SER_HALF : codec_pkg::NIB_HALF;
    tick      = (r.div >= last);
    fall      = (r.div == half - 5'h01);
    n.div     = tick ? 5'h00 : r.div + 5'h01;
    n.mclk    = (n.div < half);
    // capture the mac word just before the rising clock edge
    if (tick) begin
      n.tsh  = tx_data_i;
      n.tact = tx_en_i;
    end
    // bit slot within the nibble and phase within the bit
    bidx  = serial_mode_i ? 2'h0 : 2'(n.div / codec_pkg::BIT_LEN);
    bc    = n.div % codec_pkg::BIT_LEN;
    bitv  = n.tsh[bidx];
    first = (bc < codec_pkg::HALF_LEN);
    // line driver: mlt-3 passthrough at 100M, manchester at 10M
    if (speed_100_i) begin
      n.ltp = mlt3_pos_i;
      n.ltn = mlt3_neg_i;
    end else if (n.tact) begin
      n.ltp = (bitv == first);
      n.ltn = (bitv != first);
    end else begin
      n.ltp = 1'b0;
      n.ltn = 1'b0;
    end
    // two-flop synchronisers on the receive pair
    n.rp1     = line_rx_pos_i;
    n.rp2     = r.rp1;
    n.rn1     = line_rx_neg_i;
    n.rn2     = r.rn1;
    act       = r.rp2 ^ r.rn2;
    raw       = r.rp2 & ~r.rn2;
    edge_seen = act && (raw != r.rlv);
    if (act) begin
      n.rlv = raw;
    end
    // an edge far enough from the last mid-bit edge is a mid-bit edge
    mid    = edge_seen && (r.gc >= codec_pkg::MID_MIN);
    rbit   = r.rlv ^ r.pol;
    n.gc   = mid ? 4'h0 : ((r.gc == codec_pkg::GAP_MAX) ? r.gc : r.gc + 4'h1);
    n.wv   = 1'b0;
    pol_en = !speed_100_i || autoneg_i;
    case (r.rst)
      codec_pkg::RX_IDLE: begin
        if (mid) begin
          n.rst = codec_pkg::RX_PRE;
          n.ac  = 4'h0;
          n.lb  = rbit;
          n.ovr = 1'b0;
        end
      end
      codec_pkg::RX_PRE: begin
        if (!mid && r.gc >= codec_pkg::CARRIER_LOSS) begin
          n.rst = codec_pkg::RX_IDLE;
        end else if (mid) begin
          n.lb = rbit;
          if (rbit != r.lb) begin
            n.ac = (r.ac == 4'hf) ? r.ac : r.ac + 4'h1;
          end else if (r.ac >= codec_pkg::PRE_MIN) begin
            // repeated pair ends the preamble; zeros mean a swapped pair
            n.rst = codec_pkg::RX_DATA;
            n.nc  = 2'h0;
            if (!rbit && pol_en) begin
              n.pol = ~r.pol;
            end
          end else begin
            n.ac = 4'h0;
          end
        end
      end
      codec_pkg::RX_DATA: begin
        if (!mid && r.gc >= codec_pkg::CARRIER_LOSS) begin
          n.rst = codec_pkg::RX_IDLE;
        end else if (mid) begin
          if (serial_mode_i) begin
            n.wv = 1'b1;
            n.wd = {3'h0, rbit};
          end else begin
            n.rsh[r.nc] = rbit;
            n.nc        = r.nc + 2'h1;
            if (r.nc == 2'h3) begin
              n.wv = 1'b1;
              n.wd = {rbit, r.rsh[2:0]};
            end
          end
        end
      end
      default: begin
        n.rst = codec_pkg::RX_IDLE;
      end
    endcase
    // a word lost to a full buffer is flagged; set wins over clear
    if (r.wv && !q.wr_ready) begin
      n.ovr = 1'b1;
    end
    // present buffered words to the mac on the falling clock edge
    if (fall) begin
      n.rdv  = q.rd_valid;
      n.rdat = q.rd_valid ? q.rd_data : 4'h0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // transmit coding checks
  one_level_a: assert property (
    ($past(!speed_100_i && serial_mode_i) && r.tact && r.tsh[0] && r.div == 5'h00)
    |-> (r.ltp && !r.ltn)[*3] ##1 (!r.ltp && r.ltn)[*2])
    else $error("one bit not coded high then low");
  zero_level_a: assert property (
    ($past(!speed_100_i && serial_mode_i) && r.tact && !r.tsh[0] && r.div == 5'h00)
    |-> (!r.ltp && r.ltn)[*3] ##1 (r.ltp && !r.ltn)[*2])
    else $error("zero bit not coded low then high");
  mid_flip_a: assert property (
    ($past(!speed_100_i) && r.tact && $stable(r.tact) && $stable(r.tsh)
     && (r.div % codec_pkg::BIT_LEN) == codec_pkg::HALF_LEN)
    |-> r.ltp != $past(r.ltp))
    else $error("no mid-bit transition");
  tx_load_a: assert property (
    (!serial_mode_i && r.div == codec_pkg::NIB_LAST)
    |=> r.tact == $past(tx_en_i) && r.tsh == $past(tx_data_i))
    else $error("mac nibble not captured");
  mlt3_pass_a: assert property (
    speed_100_i |=> r.ltp == $past(mlt3_pos_i) && r.ltn == $past(mlt3_neg_i))
    else $error("mlt-3 levels not passed to line");
  // clock synthesis checks
  // the first rise after reset comes at div 1, so only div 0 rises are timed;
  // a mode change between frames can cut short the divider period in flight, as the divider is not restarted
  nib_clk_a: assert property (
    (!serial_mode_i && $rose(r.mclk) && r.div == 5'h00)
    |-> ##20 ($rose(r.mclk) || serial_mode_i))
    else $error("nibble clock period wrong");
  ser_clk_a: assert property (
    (serial_mode_i && $rose(r.mclk) && r.div == 5'h00)
    |-> ##5 ($rose(r.mclk) || !serial_mode_i))
    else $error("serial clock period wrong");
  // receive path checks
  nrz_bit_a: assert property (
    (r.wv && $past(serial_mode_i) && $past(r.rst) == codec_pkg::RX_DATA)
    |-> r.wd == {3'h0, $past(r.rlv) ^ $past(r.pol)})
    else $error("decoded bit wrong");
  nibble_pack_a: assert property (
    (r.wv && !$past(serial_mode_i)) |-> $past(r.nc) == 2'h3)
    else $error("nibble written before four bits");
  pol_sfd_a: assert property (
    $changed(r.pol) |-> $past(r.rst) == codec_pkg::RX_PRE && r.rst == codec_pkg::RX_DATA)
    else $error("polarity changed outside delimiter");
  pol_hold_a: assert property (
    $changed(r.pol) |-> $past(!speed_100_i || autoneg_i))
    else $error("polarity changed while correction off");
endmodule

//--- testbench/mac_partner.sv
// mac-side model: feeds one transmit word per mac clock, gathers received words
// assumes the codec mac clock is watched on the shared core clock
`timescale 1ns/10ps
module mac_partner (
  input  wire logic       clk_i,
  input  wire logic       mac_clk_i,
  input  wire logic       rx_dv_i,
  input  wire logic [3:0] rx_data_i,
  output logic            tx_en_o,
  output logic [3:0]      tx_data_o
);
  logic       mac_clk_r;
  logic       rise;
  logic [3:0] tx_q[$];
  logic [3:0] rx_q[$];

  // at each mac clock rise: take a valid word, then present the next one
  initial begin
    tx_en_o   = 1'b0;
    tx_data_o = 4'h0;
    mac_clk_r = 1'b0;
    rise      = 1'b0;
    forever begin
      @(posedge clk_i);
      rise      = mac_clk_i && !mac_clk_r;
      mac_clk_r = mac_clk_i;
      if (rise) begin
        if (rx_dv_i)
          rx_q.push_back(rx_data_i);
        #1;
        // idle data toggles so a stale word never looks valid
        tx_en_o   = (tx_q.size() != 0);
        tx_data_o = (tx_q.size() != 0) ? tx_q.pop_front() : ~tx_data_o;
      end
    end
  end
endmodule

//--- testbench/tenbase_manchester_codec_tb_top.sv
// bench for the manchester codec: mac model on one side, a wire loop on the line
// assumes the 50 mhz core clock and the constants of the codec package
`timescale 1ns/10ps
module tenbase_manchester_codec_tb_top;
  logic       clk, rst, serial_mode, speed_100, autoneg, mlt3_pos, mlt3_neg, swap;
  logic       line_rx_pos, line_rx_neg, mac_clk, rx_dv, rx_overrun, pol_rev;
  logic       tx_pos, tx_neg, tx_en;
  logic [3:0] rx_data, tx_data;
  logic       samp_q[$];
  int         n_errors;
  int         checks;

  tenbase_manchester_codec i_dut (
    .clk_i(clk), .rst_i(rst), .serial_mode_i(serial_mode), .speed_100_i(speed_100),
    .autoneg_i(autoneg), .tx_en_i(tx_en), .tx_data_i(tx_data), .mlt3_pos_i(mlt3_pos),
    .mlt3_neg_i(mlt3_neg), .line_rx_pos_i(line_rx_pos), .line_rx_neg_i(line_rx_neg),
    .mac_clk_o(mac_clk), .rx_dv_o(rx_dv), .rx_data_o(rx_data), .rx_overrun_o(rx_overrun),
    .polarity_reversed_o(pol_rev), .line_tx_pos_o(tx_pos), .line_tx_neg_o(tx_neg));

  mac_partner i_mac (
    .clk_i(clk), .mac_clk_i(mac_clk), .rx_dv_i(rx_dv), .rx_data_i(rx_data),
    .tx_en_o(tx_en), .tx_data_o(tx_data));

  always #10 clk = ~clk;

  // medium loop, pair optionally crossed, quiet while at 100M
  always @(posedge clk) begin
    #1;
    line_rx_pos = speed_100 ? 1'b0 : (swap ? tx_neg : tx_pos);
    line_rx_neg = speed_100 ? 1'b0 : (swap ? tx_pos : tx_neg);
  end

  // positive-wire level of every active transmit cycle at 10M
  always @(posedge clk)
    if (!speed_100 && (tx_pos || tx_neg))
      samp_q.push_back(tx_pos);

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // one looped frame: preamble, delimiter, sixteen data bits
  task automatic run_frame(input logic ser, input logic sw, input logic [15:0] dat,
                           input logic pol);
    logic b[$];
    int   n;
    int   t;
    serial_mode = ser;
    swap        = sw;
    n = 0;
    t = 0;
    // rise to rise of the mac clock
    for (int e = 0; e < 4; e++)
      while (mac_clk !== e[0] && t < 400) begin
        @(posedge clk);
        #1;
        t++;
        n += int'(e > 1);
      end
    check("mac clock period", 8'(ser ? codec_pkg::SER_DIV : codec_pkg::NIB_DIV), 8'(n));
    for (int i = 0; i < 10; i++)
      b.push_back(!i[0]);
    b.push_back(1'b1);
    b.push_back(1'b1);
    for (int i = 0; i < 16; i++)
      b.push_back(dat[i]);
    samp_q.delete();
    i_mac.rx_q.delete();
    for (int i = 0; i < b.size(); i += (ser ? 1 : 4))
      i_mac.tx_q.push_back(ser ? {3'h0, b[i]} : {b[i+3], b[i+2], b[i+1], b[i]});
    t = 0;
    while ((i_mac.rx_q.size() < (ser ? 16 : 4) || i_mac.tx_q.size() > 0 || tx_pos || tx_neg)
           && t < 3000) begin
      @(posedge clk);
      #1;
      t++;
    end
    check("frame finished", 8'h01, 8'(t < 3000));
    // one more nibble-mode mac period (four in serial mode) so that a stray extra word would show
    repeat (codec_pkg::NIB_DIV) @(posedge clk);
    #1;
    check("rx word count", ser ? 8'h10 : 8'h04, 8'(i_mac.rx_q.size()));
    for (int k = 0; k < i_mac.rx_q.size() && k < 16; k++)
      check("rx word", ser ? {7'h0, dat[k]} : {4'h0, dat[4*k +: 4]}, {4'h0, i_mac.rx_q[k]});
    check("polarity flag", {7'h0, pol}, {7'h0, pol_rev});
    check("overrun flag", 8'h00, {7'h0, rx_overrun});
    check("tx sample count", 8'(b.size() * 5), 8'(samp_q.size()));
    for (int i = 0; i < samp_q.size() && i < b.size() * 5; i++)
      check("tx level", {7'h0, (i % 5 < 3) ? b[i/5] : !b[i/5]}, {7'h0, samp_q[i]});
    $display("test frame serial %0b crossed %0b done", ser, sw);
  endtask

  // at 100M the pair copies the three-level inputs one cycle later
  task automatic mlt3_pass();
    speed_100 = 1'b1;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      #1;
      mlt3_pos = i[0];
      mlt3_neg = i[1];
      @(posedge clk);
      #1;
      check("mlt3 copy", {6'h0, i[1:0]}, {6'h0, tx_neg, tx_pos});
    end
    mlt3_pos  = 1'b0;
    mlt3_neg  = 1'b0;
    @(posedge clk);
    #1;
    speed_100 = 1'b0;
    $display("test mlt3 pass done");
  endtask

  initial begin
    {clk, serial_mode, speed_100, autoneg, mlt3_pos, mlt3_neg, swap} = 7'h00;
    rst = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    rst = 1'b0;
    @(posedge clk);
    #1;
    run_frame(1'b0, 1'b0, 16'h3ca5, 1'b0);
    autoneg = 1'b1;
    run_frame(1'b0, 1'b1, 16'hf0e1, 1'b1);
    autoneg = 1'b0;
    run_frame(1'b1, 1'b1, 16'h96c3, 1'b1);
    run_frame(1'b1, 1'b0, 16'h5a0f, 1'b0);
    mlt3_pass();
    conclude();
  end

  // cut a hang short well past the expected run time
  initial begin
    #400000;
    n_errors++;
    $display("CHECK FAILED watchdog expected finish seen timeout");
    conclude();
  end
endmodule
